// ### rtl/pio_defines.svh
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_PORT1_DATA 8'he1
`define IDX_PORT1_DIR 8'he3
`define IDX_PORT3_DATA 8'he5
`define IDX_PORT3_DIR 8'he7
`define IDX_PORT4_DATA 8'he8
`define IDX_PORT4_DIR 8'hea
`define IDX_KEY_ENABLE 8'hfb
`define IDX_PIN_FUNC 8'hf8
`define IDX_PULLUP_CTRL 8'hfc
`define IDX_DRIVE_CAP 8'hfe
`define IDX_TIMER_C_OUT 8'hff

// Implemented bit masks
`define MASK_PORT3 8'hb8
`define MASK_PORT4_DIR 8'h20
`define MASK_PORT4_DATA 8'he4
`define MASK_KEY_ENABLE 8'h0f

// Field positions
`define BIT_GROUP_PULLUP 2
`define BIT_SERIAL_ROUTE 3
`define BIT_SERIAL_SWITCH 7
`define BIT_P1_SERIAL 6
`define BIT_P3_SERIAL 3

// Converter channel codes {ch2,ch1,ch0,group}
`define ADC_CODE_P1_0 4'h9
`define ADC_CODE_P1_1 4'hb
`define ADC_CODE_P1_2 4'hd
`define ADC_CODE_P1_3 4'hf

// Timer Z modes
`define TZ_MODE_PORT 2'h0
`define TZ_MODE_CTRL 2'h1

// Reset values
`define RST_BYTE 8'h00

`endif

// ### rtl/pio_pkg.sv
package pio_pkg;

  // Drive of one 8-pin port: level and output enable per pin
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
  } pin_drive_t;

  // One shared peripheral output: data and enable
  typedef struct packed {
    logic data;
    logic oe;
  } periph_out_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage

// ### rtl/programmable_io_ports.sv
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "pio_defines.svh"

module programmable_io_ports (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] p1_pin_in,
  input wire logic [7:0] p3_pin_in,
  input wire logic [7:0] p4_pin_in,
  output pio_pkg::pin_drive_t p1_drive,
  output pio_pkg::pin_drive_t p3_drive,
  output pio_pkg::pin_drive_t p4_drive,
  output logic [3:0] p1_pullup_en,
  output logic [3:0] p1_high_drive,
  input wire logic [2:0] timer_compare_output,
  input wire logic timer_z_output,
  input wire logic [1:0] timer_z_mode_field,
  input wire logic timer_z_output_ctrl_bit,
  input wire logic [3:0] converter_channel_field,
  output logic [3:0] analog_channel_input,
  output logic [3:0] key_input_line,
  input wire pio_pkg::periph_out_t serial_unit_out,
  input wire pio_pkg::periph_out_t i2c_unit_out,
  output logic serial_unit_in,
  output logic i2c_unit_in
);
  import pio_pkg::*;

  bus_state_t bus_q;
  logic [7:0] p1_latch_q;
  logic [7:0] p3_latch_q;
  logic [7:0] p4_latch_q;
  logic [7:0] p1_dir_q;
  logic [7:0] p3_dir_q;
  logic [7:0] p4_dir_q;
  logic [7:0] pin_func_q;
  logic [7:0] pullup_q;
  logic [7:0] drive_cap_q;
  logic [7:0] timer_c_q;
  logic [7:0] key_en_q;
  logic [7:0] p1_meta_q, p1_pin_q;
  logic [7:0] p3_meta_q, p3_pin_q;
  logic [7:0] p4_meta_q, p4_pin_q;
  logic [31:0] readdata_q;
  logic wr_take;
  logic rd_start;
  logic [7:0] rd_byte;
  logic [7:0] wr_byte;
  pin_drive_t p1_d, p3_d, p4_d;
  periph_out_t shared_out;
  logic shared_line;
  logic group_pullup;
  logic [3:0] p1_plain_in;
  logic [3:0] pullup_d, high_d, analog_d, key_d;
  logic serial_in_d, i2c_in_d;
  logic [3:0] port_out_mode;

  // Pin read: input mode shows the pin, output mode the latch
  function automatic logic [7:0] port_view(input logic [7:0] dir,
                                           input logic [7:0] latch,
                                           input logic [7:0] pin);
    port_view = (dir & latch) | (~dir & pin);
  endfunction

  // Avalon slave: one wait state on every access
  assign avs_waitrequest = (avs_read | avs_write) && bus_q == BUS_IDLE;
  assign wr_take = avs_write && bus_q == BUS_ACK && avs_byteenable[0];
  assign rd_start = avs_read && bus_q == BUS_IDLE;
  assign wr_byte = avs_writedata[7:0];
  assign avs_readdata = readdata_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_q <= BUS_IDLE;
    end else if (bus_q == BUS_ACK) begin
      bus_q <= BUS_IDLE;
    end else if (avs_read | avs_write) begin
      bus_q <= BUS_ACK;
    end
  end

  // Pin inputs come from outside the clock domain
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p1_meta_q <= `RST_BYTE;
      p1_pin_q <= `RST_BYTE;
      p3_meta_q <= `RST_BYTE;
      p3_pin_q <= `RST_BYTE;
      p4_meta_q <= `RST_BYTE;
      p4_pin_q <= `RST_BYTE;
    end else begin
      p1_meta_q <= p1_pin_in;
      p1_pin_q <= p1_meta_q;
      p3_meta_q <= p3_pin_in;
      p3_pin_q <= p3_meta_q;
      p4_meta_q <= p4_pin_in;
      p4_pin_q <= p4_meta_q;
    end
  end

  // Latches load on every write, whatever the direction
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p1_latch_q <= `RST_BYTE;
      p3_latch_q <= `RST_BYTE;
      p4_latch_q <= `RST_BYTE;
    end else if (wr_take) begin
      if (avs_address == `IDX_PORT1_DATA) begin
        p1_latch_q <= wr_byte;
      end
      if (avs_address == `IDX_PORT3_DATA) begin
        p3_latch_q <= wr_byte & `MASK_PORT3;
      end
      if (avs_address == `IDX_PORT4_DATA) begin
        p4_latch_q <= wr_byte & `MASK_PORT4_DIR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p1_dir_q <= `RST_BYTE;
      p3_dir_q <= `RST_BYTE;
      p4_dir_q <= `RST_BYTE;
    end else if (wr_take) begin
      if (avs_address == `IDX_PORT1_DIR) begin
        p1_dir_q <= wr_byte;
      end
      if (avs_address == `IDX_PORT3_DIR) begin
        p3_dir_q <= wr_byte & `MASK_PORT3;
      end
      if (avs_address == `IDX_PORT4_DIR) begin
        p4_dir_q <= wr_byte & `MASK_PORT4_DIR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_func_q <= `RST_BYTE;
      pullup_q <= `RST_BYTE;
      drive_cap_q <= `RST_BYTE;
      timer_c_q <= `RST_BYTE;
      key_en_q <= `RST_BYTE;
    end else if (wr_take) begin
      if (avs_address == `IDX_PIN_FUNC) begin
        pin_func_q <= wr_byte;
      end
      if (avs_address == `IDX_PULLUP_CTRL) begin
        pullup_q <= wr_byte;
      end
      if (avs_address == `IDX_DRIVE_CAP) begin
        drive_cap_q <= wr_byte;
      end
      if (avs_address == `IDX_TIMER_C_OUT) begin
        timer_c_q <= wr_byte;
      end
      if (avs_address == `IDX_KEY_ENABLE) begin
        key_en_q <= wr_byte & `MASK_KEY_ENABLE;
      end
    end
  end

  // Read mux; unmapped indices answer zero
  always_comb begin
    rd_byte = `RST_BYTE;
    unique case (avs_address)
      `IDX_PORT1_DATA: rd_byte = port_view(p1_dir_q, p1_latch_q,
                                           p1_pin_q);
      `IDX_PORT3_DATA: rd_byte = port_view(p3_dir_q, p3_latch_q,
                                           p3_pin_q) & `MASK_PORT3;
      `IDX_PORT4_DATA: rd_byte = port_view(p4_dir_q, p4_latch_q,
                                           p4_pin_q) & `MASK_PORT4_DATA;
      `IDX_PORT1_DIR: rd_byte = p1_dir_q;
      `IDX_PORT3_DIR: rd_byte = p3_dir_q;
      `IDX_PORT4_DIR: rd_byte = p4_dir_q;
      `IDX_PIN_FUNC: rd_byte = pin_func_q;
      `IDX_PULLUP_CTRL: rd_byte = pullup_q;
      `IDX_DRIVE_CAP: rd_byte = drive_cap_q;
      `IDX_TIMER_C_OUT: rd_byte = timer_c_q;
      `IDX_KEY_ENABLE: rd_byte = key_en_q;
      default: rd_byte = `RST_BYTE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readdata_q <= 32'h0000_0000;
    end else if (rd_start) begin
      readdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // Shared serial line: unit choice and pin routing
  always_comb begin
    shared_out = pin_func_q[`BIT_SERIAL_SWITCH] ? i2c_unit_out
                                                : serial_unit_out;
    shared_line = pin_func_q[`BIT_SERIAL_ROUTE]
                ? p1_pin_q[`BIT_P1_SERIAL]
                : p3_pin_q[`BIT_P3_SERIAL];
    serial_in_d = ~pin_func_q[`BIT_SERIAL_SWITCH] & shared_line;
    i2c_in_d = pin_func_q[`BIT_SERIAL_SWITCH] & shared_line;
  end

  // Pull-up and converter only on undriven P1_0-3 inputs
  assign group_pullup = pullup_q[`BIT_GROUP_PULLUP];

  always_comb begin
    port_out_mode = p1_dir_q[3:0];
    p1_d.level = p1_latch_q;
    p1_d.oe = p1_dir_q;
    // Timer C overrides direction on P1_0-2
    for (int j = 0; j < 3; j++) begin
      if (timer_c_q[j]) begin
        p1_d.oe[j] = 1'b1;
        p1_d.level[j] = p1_latch_q[j] & timer_compare_output[j];
        port_out_mode[j] = ~p1_latch_q[j];
      end
    end
    // Timer Z on P1_3
    if (timer_z_mode_field[1] ||
        (timer_z_mode_field == `TZ_MODE_CTRL &&
         !timer_z_output_ctrl_bit)) begin
      p1_d.oe[3] = 1'b1;
      p1_d.level[3] = timer_z_output;
      port_out_mode[3] = 1'b0;
    end else if (timer_z_mode_field == `TZ_MODE_CTRL) begin
      p1_d.oe[3] = 1'b1;
      port_out_mode[3] = 1'b1;
    end
    // A driving peripheral wins over the direction bit
    if (pin_func_q[`BIT_SERIAL_ROUTE] && shared_out.oe) begin
      p1_d.oe[`BIT_P1_SERIAL] = 1'b1;
      p1_d.level[`BIT_P1_SERIAL] = shared_out.data;
    end
  end

  always_comb begin
    p3_d.level = p3_latch_q;
    p3_d.oe = p3_dir_q;
    if (!pin_func_q[`BIT_SERIAL_ROUTE] && shared_out.oe) begin
      p3_d.oe[`BIT_P3_SERIAL] = 1'b1;
      p3_d.level[`BIT_P3_SERIAL] = shared_out.data;
    end
    p4_d.level = p4_latch_q;
    p4_d.oe = p4_dir_q & `MASK_PORT4_DIR;
  end

  always_comb begin
    p1_plain_in = ~p1_d.oe[3:0] & ~{4{group_pullup}};
    pullup_d = ~p1_d.oe[3:0] & {4{group_pullup}};
    high_d = drive_cap_q[3:0] & port_out_mode & p1_d.oe[3:0];
    key_d = key_en_q[3:0] & p1_plain_in & p1_pin_q[3:0];
    analog_d[0] = p1_plain_in[0] &&
                  converter_channel_field == `ADC_CODE_P1_0;
    analog_d[1] = p1_plain_in[1] &&
                  converter_channel_field == `ADC_CODE_P1_1;
    analog_d[2] = p1_plain_in[2] &&
                  converter_channel_field == `ADC_CODE_P1_2;
    analog_d[3] = p1_plain_in[3] &&
                  timer_z_mode_field == `TZ_MODE_PORT &&
                  converter_channel_field == `ADC_CODE_P1_3;
  end

  // Pads and side outputs are registered; one cycle behind the cause, three behind a pin for the key and unit inputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p1_drive <= '0;
      p3_drive <= '0;
      p4_drive <= '0;
    end else begin
      p1_drive <= p1_d;
      p3_drive <= p3_d;
      p4_drive <= p4_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p1_pullup_en <= 4'h0;
      p1_high_drive <= 4'h0;
      analog_channel_input <= 4'h0;
      key_input_line <= 4'h0;
      serial_unit_in <= 1'b0;
      i2c_unit_in <= 1'b0;
    end else begin
      p1_pullup_en <= pullup_d;
      p1_high_drive <= high_d;
      analog_channel_input <= analog_d;
      key_input_line <= key_d;
      serial_unit_in <= serial_in_d;
      i2c_unit_in <= i2c_in_d;
    end
  end

endmodule // programmable_io_ports

// ### sim/io_props.sv
`timescale 1ns/1ns
`include "pio_defines.svh"
module io_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire pio_pkg::pin_drive_t p1_drive,
  input wire logic timer_z_output,
  input wire logic [1:0] timer_z_mode_field,
  input wire logic timer_z_output_ctrl_bit,
  input wire logic [3:0] converter_channel_field,
  input wire logic [3:0] analog_channel_input
);
  import pio_pkg::*;
  logic ack;
  assign ack = avs_read && !avs_waitrequest;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_read_wait_once: assert property (
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer not one cycle late");
  a_write_wait_once: assert property (
    $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("write answer not one cycle late");
  a_p3_dir_mask: assert property (
    ack && avs_address == `IDX_PORT3_DIR |->
    (avs_readdata[7:0] & ~`MASK_PORT3) == 8'h00)
    else $error("port3 direction spare bits set");
  a_p4_dir_mask: assert property (
    ack && avs_address == `IDX_PORT4_DIR |->
    (avs_readdata[7:0] & ~`MASK_PORT4_DIR) == 8'h00)
    else $error("port4 direction spare bits set");
  a_p3_data_mask: assert property (
    ack && avs_address == `IDX_PORT3_DATA |->
    (avs_readdata[7:0] & ~`MASK_PORT3) == 8'h00)
    else $error("port3 data spare bits set");
  a_tz_mode_high: assert property (
    $past(!sys_rst) && $past(timer_z_mode_field[1]) |->
    p1_drive.oe[3] && p1_drive.level[3] == $past(timer_z_output))
    else $error("timer z output missing in mode 1x");
  a_tz_ctrl_low: assert property (
    $past(!sys_rst) && $past(timer_z_mode_field) == 2'h1 &&
    $past(!timer_z_output_ctrl_bit) |->
    p1_drive.oe[3] && p1_drive.level[3] == $past(timer_z_output))
    else $error("timer z output missing in mode 01");
  a_analog_gate: assert property (
    analog_channel_input[3] |->
    $past(converter_channel_field) == `ADC_CODE_P1_3 &&
    $past(timer_z_mode_field) == `TZ_MODE_PORT)
    else $error("p1_3 routed to converter wrongly");
endmodule // io_props

bind programmable_io_ports io_props u_props (.clk(clk),
  .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .p1_drive(p1_drive),
  .timer_z_output(timer_z_output), .timer_z_mode_field(timer_z_mode_field),
  .timer_z_output_ctrl_bit(timer_z_output_ctrl_bit),
  .converter_channel_field(converter_channel_field),
  .analog_channel_input(analog_channel_input));

// ### sim/board_pins.sv
`timescale 1ns/1ns
module board_pins (
  input wire pio_pkg::pin_drive_t drv,
  input wire logic [7:0] pull_up,
  input wire logic [7:0] ext,
  output logic [7:0] pin
);
  // Undriven pin follows pull-up, else the outside source
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = drv.oe[i] ? drv.level[i] : (pull_up[i] ? 1'b1 : ext[i]);
    end
  end
endmodule // board_pins

// ### sim/testbench.sv
`timescale 1ns/1ns
`include "pio_defines.svh"
module testbench;
  import pio_pkg::*;
  logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
  logic [7:0] avs_address = 0, rdata, ext1 = 0, ext3 = 0, ext4 = 0;
  logic [31:0] avs_writedata = 0, avs_readdata;
  logic [3:0] avs_byteenable = 4'h1, pu, hd, cf = 0, an, key;
  logic [7:0] p1_in, p3_in, p4_in;
  pin_drive_t p1_drv, p3_drv, p4_drv;
  logic [2:0] tc = 0;
  logic tz = 0, tzc = 0, s_in, i_in, avs_waitrequest;
  logic [1:0] tzm = 0;
  periph_out_t su = '0, iu = '0;
  logic [3:0] codes [4] = '{`ADC_CODE_P1_0, `ADC_CODE_P1_1,
    `ADC_CODE_P1_2, `ADC_CODE_P1_3};
  int error_cnt = 0, check_count = 0;
  always #4 clk = ~clk;
  programmable_io_ports u_dut (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .p1_pin_in(p1_in), .p3_pin_in(p3_in), .p4_pin_in(p4_in),
    .p1_drive(p1_drv), .p3_drive(p3_drv), .p4_drive(p4_drv),
    .p1_pullup_en(pu), .p1_high_drive(hd), .timer_compare_output(tc),
    .timer_z_output(tz), .timer_z_mode_field(tzm),
    .timer_z_output_ctrl_bit(tzc), .converter_channel_field(cf),
    .analog_channel_input(an), .key_input_line(key),
    .serial_unit_out(su), .i2c_unit_out(iu), .serial_unit_in(s_in),
    .i2c_unit_in(i_in));
  board_pins u_b1 (.drv(p1_drv), .pull_up({4'h0, pu}), .ext(ext1),
    .pin(p1_in));
  board_pins u_b3 (.drv(p3_drv), .pull_up(8'h00), .ext(ext3), .pin(p3_in));
  board_pins u_b4 (.drv(p4_drv), .pull_up(8'h00), .ext(ext4), .pin(p4_in));
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // Waits as long as the slave stalls; only the watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata[7:0];
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    xfer(0, a, 8'h00);
    chk("readdata", e, rdata);
  endtask
  task automatic wr(input logic [7:0] a, d);
    xfer(1, a, d);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 0;
    rd(`IDX_PIN_FUNC, 8'h00);
    rd(`IDX_PORT1_DIR, 8'h00);
    rd(8'h00, 8'h00);
    wr(`IDX_PORT3_DIR, 8'hff);
    rd(`IDX_PORT3_DIR, 8'hb8);
    wr(`IDX_PORT4_DIR, 8'hff);
    rd(`IDX_PORT4_DIR, 8'h20);
    wr(`IDX_PORT3_DATA, 8'hff);
    rd(`IDX_PORT3_DATA, 8'hb8);
    ext4 <= 8'hc4;
    wr(`IDX_PORT4_DATA, 8'hff);
    settle;
    chk("p4 drive", 8'h20, p4_drv.level & p4_drv.oe);
    rd(`IDX_PORT4_DATA, 8'he4);
    ext1 <= 8'h3c;
    wr(`IDX_PORT1_DATA, 8'ha5);
    settle;
    chk("p1 oe", 8'h00, p1_drv.oe);
    rd(`IDX_PORT1_DATA, 8'h3c);
    wr(`IDX_PORT1_DIR, 8'h0f);
    settle;
    chk("p1 level", 8'h05, p1_drv.level & p1_drv.oe);
    rd(`IDX_PORT1_DATA, 8'h35);
    wr(`IDX_PULLUP_CTRL, 8'h04);
    wr(`IDX_DRIVE_CAP, 8'h0f);
    settle;
    chk("pull/drive", 8'h0f, {pu, hd});
    wr(`IDX_PORT1_DIR, 8'h00);
    settle;
    chk("pull/drive", 8'hf0, {pu, hd});
    rd(`IDX_PORT1_DATA, 8'h3f);
    wr(`IDX_PULLUP_CTRL, 8'h00);
    tc <= 3'b011;
    wr(`IDX_TIMER_C_OUT, 8'h07);
    settle;
    chk("timer c", 8'h71, {p1_drv.oe[3:0], p1_drv.level[3:0]});
    wr(`IDX_TIMER_C_OUT, 8'h00);
    tz <= 1;
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 2; c++) begin
        tzm <= m[1:0];
        tzc <= c[0];
        settle;
        chk("timer z", {6'h0, m != 0, m > 1 || (m == 1 && c == 0)},
          {6'h0, p1_drv.oe[3], p1_drv.level[3]});
      end
    end
    tzm <= 0;
    for (int j = 0; j < 4; j++) begin
      cf <= codes[j];
      settle;
      chk("analog", 8'h01 << j, {4'h0, an});
    end
    cf <= 0;
    ext1 <= 8'h0a;
    wr(`IDX_KEY_ENABLE, 8'h0f);
    settle;
    chk("key", 8'h0a, {4'h0, key});
    su <= '{data: 1'b0, oe: 1'b1};
    iu <= '{data: 1'b1, oe: 1'b1};
    settle;
    chk("p3_3", 8'h02, {6'h0, p3_drv.oe[3], p3_drv.level[3]});
    wr(`IDX_PIN_FUNC, 8'h08);
    settle;
    chk("p1_6", 8'h02, {6'h0, p1_drv.oe[6], p1_drv.level[6]});
    wr(`IDX_PIN_FUNC, 8'h88);
    settle;
    chk("p1_6", 8'h03, {6'h0, p1_drv.oe[6], p1_drv.level[6]});
    su <= '0;
    iu <= '0;
    ext1 <= 8'h40;
    settle;
    chk("unit in", 8'h01, {6'h0, s_in, i_in});
    close_out;
  end
endmodule // testbench
